// [rtd_params.svh]
`ifndef RTD_PARAMS_SVH
`define RTD_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RTD_IDX_TRIG_AB      7'd58
`define RTD_IDX_TRIG_C       7'd59
`define RTD_IDX_CMPZ_B0      7'd60
`define RTD_IDX_CMPZ_B1      7'd61
`define RTD_IDX_CMPZ_B2      7'd62
`define RTD_IDX_CMPZ_B3      7'd63
`define RTD_IDX_CMPZ_MASK    7'd64
`define RTD_IDX_CMPO_B0      7'd65
`define RTD_IDX_CMPO_B1      7'd66
`define RTD_IDX_CMPO_B2      7'd67
`define RTD_IDX_CMPO_B3      7'd68
`define RTD_IDX_CMPO_MASK    7'd69
`define RTD_IDX_SIGN_BITS    7'd70
`define RTD_IDX_DEV_B0       7'd71
`define RTD_IDX_DEV_B1       7'd72
`define RTD_IDX_DEV_B2       7'd73
`define RTD_IDX_DEV_B3       7'd74
`define RTD_IDX_DEV_TRIG_LO  7'd75
`define RTD_IDX_DEV_TRIG_HI  7'd76
`define RTD_IDX_STATUS       7'd80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTD_POS_TRIG_A       4
`define RTD_POS_TRIG_B       0
`define RTD_POS_TRIG_C       4
`define RTD_POS_SIGN_CMPZ    0
`define RTD_POS_SIGN_CMPO    1
`define RTD_POS_SIGN_DEV     2
`define RTD_POS_DEV_TRIG_LO  3
`define RTD_POS_DEV_TRIG_HI  4
`define RTD_POS_ST_CMPZ      0
`define RTD_POS_ST_CMPO      1
`define RTD_POS_ST_TRIG_A    2
`define RTD_POS_ST_TRIG_B    3
`define RTD_POS_ST_TRIG_C    4
`define RTD_POS_ST_DEV       5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTD_RST_SEL          4'h0
`define RTD_RST_VALUE        33'h0_0000_0000
`define RTD_RST_MASK         8'h00
`define RTD_RST_DEV_SEL      2'h0

`endif

// [rtd_pkg.sv]
`default_nettype none

package rtd_pkg;

    // Trigger source codes of the 4-bit selectors
    typedef enum logic [3:0] {
        RTD_SRC_NEVER       = 4'h0,
        RTD_SRC_T1_RISE     = 4'h1,
        RTD_SRC_T2_RISE     = 4'h2,
        RTD_SRC_MOD_RISE    = 4'h3,
        RTD_SRC_LOCK_RISE   = 4'h4,
        RTD_SRC_CMPZ_LEVEL  = 4'h5,
        RTD_SRC_FL_RISE     = 4'h6,
        RTD_SRC_FLAG_RISE   = 4'h7,
        RTD_SRC_ALWAYS      = 4'h8,
        RTD_SRC_T1_FALL     = 4'h9,
        RTD_SRC_T2_FALL     = 4'hA,
        RTD_SRC_MOD_FALL    = 4'hB,
        RTD_SRC_LOCK_FALL   = 4'hC,
        RTD_SRC_CMPO_LEVEL  = 4'hD,
        RTD_SRC_UNUSED      = 4'hE,
        RTD_SRC_FLAG_FALL   = 4'hF
    } rtd_src_t;

    // Deviation trigger choice
    typedef enum logic [1:0] {
        RTD_DEV_ALWAYS = 2'h0,
        RTD_DEV_TRIG_A = 2'h1,
        RTD_DEV_TRIG_B = 2'h2,
        RTD_DEV_TRIG_C = 2'h3
    } rtd_dev_sel_t;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [8:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rtd_wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } rtd_wb_rsp_t;

    // Asynchronous trigger pins
    typedef struct packed {
        logic trigger_terminal_one;
        logic trigger_terminal_two;
        logic modulation_terminal;
        logic digital_lock_detect;
    } rtd_pins_t;

    // State of the ramp engine on the same clock
    typedef struct packed {
        logic signed [32:0] accumulator;
        logic [2:0]         segment;
        logic               increment_negative;
        logic               segment_flag_zero;
        logic               segment_fastlock_output;
    } rtd_ramp_t;

    // Results toward the ramp engine
    typedef struct packed {
        logic        trigger_a;
        logic        trigger_b;
        logic        trigger_c;
        logic        comparator_zero_detect;
        logic        comparator_one_detect;
        logic        deviation_active;
        logic [32:0] deviation_offset;
    } rtd_out_t;

    // Whole block state
    typedef struct packed {
        logic [3:0]  trigger_a_source_select;
        logic [3:0]  trigger_b_source_select;
        logic [3:0]  trigger_c_source_select;
        logic [32:0] comparator_zero_threshold;
        logic [32:0] comparator_one_threshold;
        logic [32:0] deviation_value;
        logic [7:0]  comparator_zero_segment_mask;
        logic [7:0]  comparator_one_segment_mask;
        logic [1:0]  deviation_trigger_select;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  sync3;
        logic [3:0]  pin_level;
        logic [3:0]  pin_prev;
        logic        flag_prev;
        logic        fastlock_prev;
        rtd_out_t    out;
        rtd_wb_rsp_t rsp;
    } rtd_state_t;

endpackage

`default_nettype wire

// [rtd_ramp_trigger.sv]
// Register access over Wishbone was left to the implementer.
`include "rtd_params.svh"
`default_nettype none

module rtd_ramp_trigger (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire rtd_pkg::rtd_wb_req_t wb_req,
    output var rtd_pkg::rtd_wb_rsp_t wb_rsp,
    input  wire rtd_pkg::rtd_pins_t  pins,
    input  wire rtd_pkg::rtd_ramp_t  ramp,
    output var rtd_pkg::rtd_out_t    result
);
    import rtd_pkg::*;

    rtd_state_t st;
    rtd_state_t next_st;

    // ----------------------------------------------------------------
    // Trigger source decode
    // ----------------------------------------------------------------
    // Shared by the three selectors; events are one-cycle pulses, levels hold
    function automatic logic pick_source(
        input logic [3:0] code,
        input logic [3:0] rise,
        input logic [3:0] fall,
        input logic       fl_rise,
        input logic       flag_rise,
        input logic       flag_fall,
        input logic       cmpz,
        input logic       cmpo
    );
        logic hit;
        hit = 1'b0;
        unique case (rtd_src_t'(code))
            RTD_SRC_NEVER:      hit = 1'b0;
            RTD_SRC_T1_RISE:    hit = rise[3];
            RTD_SRC_T2_RISE:    hit = rise[2];
            RTD_SRC_MOD_RISE:   hit = rise[1];
            RTD_SRC_LOCK_RISE:  hit = rise[0];
            RTD_SRC_CMPZ_LEVEL: hit = cmpz;
            RTD_SRC_FL_RISE:    hit = fl_rise;
            RTD_SRC_FLAG_RISE:  hit = flag_rise;
            RTD_SRC_ALWAYS:     hit = 1'b1;
            RTD_SRC_T1_FALL:    hit = fall[3];
            RTD_SRC_T2_FALL:    hit = fall[2];
            RTD_SRC_MOD_FALL:   hit = fall[1];
            RTD_SRC_LOCK_FALL:  hit = fall[0];
            RTD_SRC_CMPO_LEVEL: hit = cmpo;
            RTD_SRC_UNUSED:     hit = 1'b0;
            RTD_SRC_FLAG_FALL:  hit = flag_fall;
        endcase
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // Comparator
    // ----------------------------------------------------------------
    // Direction follows the sign of the active segment's increment
    function automatic logic compare(
        input logic signed [32:0] acc,
        input logic signed [32:0] thr,
        input logic [7:0]         mask,
        input logic [2:0]         seg,
        input logic               down
    );
        logic reached;
        reached = down ? (acc <= thr) : (acc >= thr);
        return reached & mask[seg];
    endfunction

    // ----------------------------------------------------------------
    // Register read view
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_reg(input rtd_state_t s, input logic [6:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `RTD_IDX_TRIG_AB:     v[`RTD_POS_TRIG_A +: 4] = s.trigger_a_source_select;
            `RTD_IDX_TRIG_C: begin
                v[`RTD_POS_TRIG_B +: 4] = s.trigger_b_source_select;
                v[`RTD_POS_TRIG_C +: 4] = s.trigger_c_source_select;
            end
            `RTD_IDX_CMPZ_B0:     v = s.comparator_zero_threshold[7:0];
            `RTD_IDX_CMPZ_B1:     v = s.comparator_zero_threshold[15:8];
            `RTD_IDX_CMPZ_B2:     v = s.comparator_zero_threshold[23:16];
            `RTD_IDX_CMPZ_B3:     v = s.comparator_zero_threshold[31:24];
            `RTD_IDX_CMPZ_MASK:   v = s.comparator_zero_segment_mask;
            `RTD_IDX_CMPO_B0:     v = s.comparator_one_threshold[7:0];
            `RTD_IDX_CMPO_B1:     v = s.comparator_one_threshold[15:8];
            `RTD_IDX_CMPO_B2:     v = s.comparator_one_threshold[23:16];
            `RTD_IDX_CMPO_B3:     v = s.comparator_one_threshold[31:24];
            `RTD_IDX_CMPO_MASK:   v = s.comparator_one_segment_mask;
            `RTD_IDX_SIGN_BITS: begin
                v[`RTD_POS_SIGN_CMPZ] = s.comparator_zero_threshold[32];
                v[`RTD_POS_SIGN_CMPO] = s.comparator_one_threshold[32];
                v[`RTD_POS_SIGN_DEV]  = s.deviation_value[32];
            end
            `RTD_IDX_DEV_B0:      v = s.deviation_value[7:0];
            `RTD_IDX_DEV_B1:      v = s.deviation_value[15:8];
            `RTD_IDX_DEV_B2:      v = s.deviation_value[23:16];
            `RTD_IDX_DEV_B3:      v = s.deviation_value[31:24];
            `RTD_IDX_DEV_TRIG_LO: v[`RTD_POS_DEV_TRIG_LO] = s.deviation_trigger_select[0];
            `RTD_IDX_DEV_TRIG_HI: v[`RTD_POS_DEV_TRIG_HI] = s.deviation_trigger_select[1];
            `RTD_IDX_STATUS: begin
                v[`RTD_POS_ST_CMPZ]   = s.out.comparator_zero_detect;
                v[`RTD_POS_ST_CMPO]   = s.out.comparator_one_detect;
                v[`RTD_POS_ST_TRIG_A] = s.out.trigger_a;
                v[`RTD_POS_ST_TRIG_B] = s.out.trigger_b;
                v[`RTD_POS_ST_TRIG_C] = s.out.trigger_c;
                v[`RTD_POS_ST_DEV]    = s.out.deviation_active;
            end
            default:              v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [3:0] rise;
    logic [3:0] fall;
    logic       fl_rise;
    logic       flag_rise;
    logic       flag_fall;
    logic       req;
    logic       wr;
    logic [6:0] idx;
    logic [7:0] wd;
    logic       dev_on;

    // Edges of filtered pins and of same-clock ramp flags
    assign rise      = st.pin_level & ~st.pin_prev;
    assign fall      = ~st.pin_level & st.pin_prev;
    assign fl_rise   = ramp.segment_fastlock_output & ~st.fastlock_prev;
    assign flag_rise = ramp.segment_flag_zero & ~st.flag_prev;
    assign flag_fall = ~ramp.segment_flag_zero & st.flag_prev;

    // Bus decode; new request only when no ack is out, so ack drops after one cycle
    assign req = wb_req.cyc & wb_req.stb & ~st.rsp.ack;
    assign wr  = req & wb_req.we & wb_req.sel[0];
    assign idx = wb_req.adr[8:2];
    assign wd  = wb_req.dat[7:0];

    always_comb begin
        next_st = st;

        // Pins: three flops, level follows once stages two and three agree
        next_st.sync1 = {pins.trigger_terminal_one, pins.trigger_terminal_two,
                         pins.modulation_terminal, pins.digital_lock_detect};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < 4; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.pin_level[i] = st.sync3[i];
            end
        end
        next_st.pin_prev      = st.pin_level;
        next_st.flag_prev     = ramp.segment_flag_zero;
        next_st.fastlock_prev = ramp.segment_fastlock_output;

        // Comparators against the full 33-bit signed thresholds
        next_st.out.comparator_zero_detect = compare(ramp.accumulator,
            $signed(st.comparator_zero_threshold), st.comparator_zero_segment_mask,
            ramp.segment, ramp.increment_negative);
        next_st.out.comparator_one_detect = compare(ramp.accumulator,
            $signed(st.comparator_one_threshold), st.comparator_one_segment_mask,
            ramp.segment, ramp.increment_negative);

        // Trigger outputs
        next_st.out.trigger_a = pick_source(st.trigger_a_source_select, rise, fall, fl_rise, flag_rise,
            flag_fall, st.out.comparator_zero_detect, st.out.comparator_one_detect);
        next_st.out.trigger_b = pick_source(st.trigger_b_source_select, rise, fall, fl_rise, flag_rise,
            flag_fall, st.out.comparator_zero_detect, st.out.comparator_one_detect);
        next_st.out.trigger_c = pick_source(st.trigger_c_source_select, rise, fall, fl_rise, flag_rise,
            flag_fall, st.out.comparator_zero_detect, st.out.comparator_one_detect);

        // Deviation gating; a zero value gives no offset even when active
        unique case (rtd_dev_sel_t'(st.deviation_trigger_select))
            RTD_DEV_ALWAYS: dev_on = 1'b1;
            RTD_DEV_TRIG_A: dev_on = st.out.trigger_a;
            RTD_DEV_TRIG_B: dev_on = st.out.trigger_b;
            RTD_DEV_TRIG_C: dev_on = st.out.trigger_c;
        endcase
        next_st.out.deviation_active = dev_on;
        next_st.out.deviation_offset = dev_on ? st.deviation_value : `RTD_RST_VALUE;

        // Register writes through byte lane zero only
        if (wr) begin
            unique case (idx)
                `RTD_IDX_TRIG_AB:     next_st.trigger_a_source_select = wd[`RTD_POS_TRIG_A +: 4];
                `RTD_IDX_TRIG_C: begin
                    next_st.trigger_b_source_select = wd[`RTD_POS_TRIG_B +: 4];
                    next_st.trigger_c_source_select = wd[`RTD_POS_TRIG_C +: 4];
                end
                `RTD_IDX_CMPZ_B0:     next_st.comparator_zero_threshold[7:0]   = wd;
                `RTD_IDX_CMPZ_B1:     next_st.comparator_zero_threshold[15:8]  = wd;
                `RTD_IDX_CMPZ_B2:     next_st.comparator_zero_threshold[23:16] = wd;
                `RTD_IDX_CMPZ_B3:     next_st.comparator_zero_threshold[31:24] = wd;
                `RTD_IDX_CMPZ_MASK:   next_st.comparator_zero_segment_mask     = wd;
                `RTD_IDX_CMPO_B0:     next_st.comparator_one_threshold[7:0]    = wd;
                `RTD_IDX_CMPO_B1:     next_st.comparator_one_threshold[15:8]   = wd;
                `RTD_IDX_CMPO_B2:     next_st.comparator_one_threshold[23:16]  = wd;
                `RTD_IDX_CMPO_B3:     next_st.comparator_one_threshold[31:24]  = wd;
                `RTD_IDX_CMPO_MASK:   next_st.comparator_one_segment_mask      = wd;
                `RTD_IDX_SIGN_BITS: begin
                    next_st.comparator_zero_threshold[32] = wd[`RTD_POS_SIGN_CMPZ];
                    next_st.comparator_one_threshold[32]  = wd[`RTD_POS_SIGN_CMPO];
                    next_st.deviation_value[32]           = wd[`RTD_POS_SIGN_DEV];
                end
                `RTD_IDX_DEV_B0:      next_st.deviation_value[7:0]   = wd;
                `RTD_IDX_DEV_B1:      next_st.deviation_value[15:8]  = wd;
                `RTD_IDX_DEV_B2:      next_st.deviation_value[23:16] = wd;
                `RTD_IDX_DEV_B3:      next_st.deviation_value[31:24] = wd;
                `RTD_IDX_DEV_TRIG_LO: next_st.deviation_trigger_select[0] = wd[`RTD_POS_DEV_TRIG_LO];
                `RTD_IDX_DEV_TRIG_HI: next_st.deviation_trigger_select[1] = wd[`RTD_POS_DEV_TRIG_HI];
                default: ;
            endcase
        end

        // One-cycle ack; unmapped addresses answer zero and drop writes
        next_st.rsp.ack = req;
        next_st.rsp.dat = req ? {24'h00_0000, read_reg(st, idx)} : 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st                              <= '0;
            st.trigger_a_source_select      <= `RTD_RST_SEL;
            st.trigger_b_source_select      <= `RTD_RST_SEL;
            st.trigger_c_source_select      <= `RTD_RST_SEL;
            st.comparator_zero_threshold    <= `RTD_RST_VALUE;
            st.comparator_one_threshold     <= `RTD_RST_VALUE;
            st.deviation_value              <= `RTD_RST_VALUE;
            st.comparator_zero_segment_mask <= `RTD_RST_MASK;
            st.comparator_one_segment_mask  <= `RTD_RST_MASK;
            st.deviation_trigger_select     <= `RTD_RST_DEV_SEL;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs straight from state
    // ----------------------------------------------------------------
    assign wb_rsp = st.rsp;
    assign result = st.out;

endmodule

`default_nettype wire

// [rtd_checker.sv]
`default_nettype none

module rtd_checker (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire rtd_pkg::rtd_wb_req_t wb_req,
    input wire rtd_pkg::rtd_wb_rsp_t wb_rsp,
    input wire rtd_pkg::rtd_pins_t   pins,
    input wire rtd_pkg::rtd_ramp_t   ramp,
    input wire rtd_pkg::rtd_out_t    result
);
    import rtd_pkg::*;

    // ----------------------------------------------------------
    // Register shadow and expected results
    // ----------------------------------------------------------
    logic [7:0]              rf [58:76];
    wire logic               take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    wire logic [6:0]         idx  = wb_req.adr[8:2];
    wire logic signed [32:0] thr0 = {rf[70][0], rf[63], rf[62], rf[61], rf[60]};
    wire logic signed [32:0] thr1 = {rf[70][1], rf[68], rf[67], rf[66], rf[65]};
    wire logic signed [32:0] acc  = ramp.accumulator;
    wire logic               dn   = ramp.increment_negative;
    wire logic               e0   = rf[64][ramp.segment] && (dn ? acc <= thr0 : acc >= thr0);
    wire logic               e1   = rf[69][ramp.segment] && (dn ? acc <= thr1 : acc >= thr1);
    wire logic [32:0]        dev  = {rf[70][2], rf[74], rf[73], rf[72], rf[71]};
    wire logic [3:0]         tv   = {result.trigger_c, result.trigger_b, result.trigger_a, 1'b1};
    wire logic               ed   = tv[{rf[76][4], rf[75][3]}];
    wire logic [3:0]         sa   = rf[58][7:4];
    wire logic               lchk = sa inside {4'h0, 4'h5, 4'h8, 4'hD, 4'hE};
    wire logic               lexp = sa == 4'h8 || (sa == 4'h5 && result.comparator_zero_detect)
                                    || (sa == 4'hD && result.comparator_one_detect);

    // Writes land at the taking edge, the same edge the slave uses
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 58; i < 77; i++)
                rf[i] <= 8'h00;
        end else if (take && wb_req.we && wb_req.sel[0] && idx >= 7'd58 && idx <= 7'd76) begin
            rf[idx] <= wb_req.dat[7:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // One ack in the cycle after the take, then low again
    sequence s_take; take; endsequence
    sequence s_ack; wb_rsp.ack ##1 !wb_rsp.ack; endsequence
    property p_answer; s_take |=> s_ack; endproperty
    property p_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000; endproperty
    property p_upper; wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h00_0000; endproperty
    property p_comparator_zero_detect; result.comparator_zero_detect == $past(e0); endproperty
    property p_comparator_one_detect; result.comparator_one_detect == $past(e1); endproperty
    // First edge after release still shows the reset value
    property p_dev; result.deviation_active == ($past(sys_rst) ? 1'b0 : $past(ed)); endproperty
    property p_off; result.deviation_offset == (result.deviation_active ? $past(dev) : 33'h0); endproperty
    property p_lvl; $past(lchk) |-> result.trigger_a == $past(lexp); endproperty

    a_answer: assert property (p_answer) else $error("bus answer wrong");
    a_idle: assert property (p_idle) else $error("read data outside ack");
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    a_comparator_zero_detect: assert property (p_comparator_zero_detect) else $error("comparator zero detect wrong");
    a_comparator_one_detect: assert property (p_comparator_one_detect) else $error("comparator one detect wrong");
    a_dev: assert property (p_dev) else $error("deviation active wrong");
    a_off: assert property (p_off) else $error("deviation offset wrong");
    a_lvl: assert property (p_lvl) else $error("level trigger wrong");
endmodule

`default_nettype wire

// [tb_top.sv]
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtd_pkg::*;

    // ----------------------------------------------------------
    // Stimulus, design and reference model
    // ----------------------------------------------------------
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    rtd_wb_req_t        wb_req = '0;
    rtd_wb_rsp_t        wb_rsp;
    rtd_out_t           result;
    logic signed [32:0] acc_in = '0;
    logic [3:0]         seg_in = '0;   // Top bit is the down flag
    logic [5:0]         src = '0;      // Pins, flag zero, fastlock
    logic [31:0]        seed = 32'h0000_2E37;
    logic [7:0]         mreg [58:76];
    int                 errors = 0;
    int                 checks_done = 0;
    int                 cycles = 0;
    int                 codes [11] = '{1, 2, 3, 4, 6, 7, 9, 10, 11, 12, 15};
    int                 srcs [11] = '{0, 1, 2, 3, 5, 4, 0, 1, 2, 3, 4};
    wire rtd_pins_t     pins = {src[0], src[1], src[2], src[3]};
    wire rtd_ramp_t     ramp = {acc_in, seg_in[2:0], seg_in[3], src[4], src[5]};

    rtd_ramp_trigger uut (.clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
                          .pins(pins), .ramp(ramp), .result(result));

    // Clock and hang guard
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            final_report();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Readable bits per index; bits owned by other blocks read zero
    function automatic logic [7:0] rmask(int i);
        return i == 58 ? 8'hF0 : i == 70 ? 8'h07 : i == 75 ? 8'h08 : i == 76 ? 8'h10
             : (i >= 59 && i <= 74) ? 8'hFF : 8'h00;
    endfunction

    function automatic logic signed [32:0] thr(int b, int s);
        return {mreg[70][s], mreg[b + 3], mreg[b + 2], mreg[b + 1], mreg[b]};
    endfunction

    function automatic logic cexp(int b, int s);
        return mreg[b + 4][seg_in[2:0]] && (seg_in[3] ? acc_in <= thr(b, s) : acc_in >= thr(b, s));
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: request held until ack is sampled, then released
    task automatic xfer(input logic we, input int idx, input logic [3:0] sel, input logic [7:0] wd,
                        output logic [31:0] rd);
        int n = 0;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, 9'(idx * 4), sel, {24'h00_0000, wd}};
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        check(n, 2);
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        logic [31:0] rd;
        xfer(1'b1, idx, 4'hF, d, rd);
        if (idx >= 58 && idx <= 76)
            mreg[idx] = d & rmask(idx);
    endtask

    task automatic rchk(input int idx);
        logic [31:0] rd;
        xfer(1'b0, idx, 4'hF, 8'h00, rd);
        check(rd, {24'h00_0000, (idx >= 58 && idx <= 76) ? mreg[idx] : 8'h00});
    endtask

    task automatic final_report();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] rd;
        logic [32:0] dv;
        logic        e0;
        logic        e1;
        integer      cnt;
        for (int i = 58; i < 77; i++)
            mreg[i] = 8'h00;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 56; i < 80; i++)
            rchk(i);
        for (int i = 56; i < 81; i++)
            wr(i, 8'(rnd()));
        xfer(1'b1, 64, 4'hE, 8'h5A, rd);                          // Lane zero off: ignored
        for (int i = 56; i < 80; i++)
            rchk(i);
        // Random ramp traffic, a quarter of it at the threshold edge
        for (int p = 0; p < 2; p++) begin
            wr(58, p ? 8'h50 : 8'hD0);
            for (int i = 0; i < 150; i++) begin
                @(posedge clk);
                rd = rnd();
                acc_in <= rd[1:0] == 2'b00 ? thr(60 + 5 * rd[2], rd[2]) + 33'(rd[4:3]) - 33'd1
                                           : {rd[31], rnd()};
                seg_in <= rd[8:5];
                @(negedge clk);
                if (i > 0)
                    check(result.comparator_zero_detect, e0);
                if (i > 0)
                    check(result.comparator_one_detect, e1);
                e0 = cexp(60, 0);
                e1 = cexp(65, 1);
            end
        end
        // Each edge code: one pulse on its own edge, none on the other
        @(posedge clk);
        acc_in <= '0;
        seg_in <= '0;
        wr(59, 8'h00);
        for (int k = 0; k < 11; k++) begin
            wr(58, 8'(codes[k] << 4));
            for (int lv = 1; lv >= 0; lv--) begin
                @(posedge clk);
                src[srcs[k]] <= lv[0];
                cnt = 0;
                repeat (12) begin
                    @(negedge clk);
                    cnt = cnt + result.trigger_a;
                end
                check(cnt, (lv == 1) == (codes[k] < 8));
            end
        end
        // Deviation by each choice; B is parked on the unused code
        wr(58, 8'h80);
        wr(59, 8'h8E);
        for (int d = 0; d < 4; d++) begin
            dv = 33'({rnd(), rnd()});
            wr(70, {5'h00, dv[32], 2'h0});
            for (int b = 0; b < 4; b++)
                wr(71 + b, dv[8 * b +: 8]);
            wr(75, d[0] ? 8'h08 : 8'h00);
            wr(76, d[1] ? 8'h10 : 8'h00);
            repeat (3) @(posedge clk);
            @(negedge clk);
            check(result.deviation_active, d != 2);
            check(result.deviation_offset, d != 2 ? dv : 33'h0);
            xfer(1'b0, 80, 4'hF, 8'h00, rd);
            check(rd, {26'h0, 1'(d != 2), 3'h5, cexp(65, 1), cexp(60, 0)});
        end
        for (int i = 70; i < 75; i++)
            wr(i, 8'h00);
        final_report();
    end
endmodule

bind rtd_ramp_trigger rtd_checker chk (.clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
                                       .pins(pins), .ramp(ramp), .result(result));

`default_nettype wire
